// >>> slor_far_end.sv
`timescale 1ns/1ps
module slor_far_end
   import slor_pkg::*;
(
   // Clock
   input  wire logic clk_i,
   // Framer side
   output slor_rx_t  rx_o,
   output logic      tx_frame_o
);

   initial
   begin
      rx_o       = '0;
      tx_frame_o = 1'b0;
   end

   // One event: 0 remote defect, 1 alarm, 2 parity error, 3 far-end error
   task automatic fire(input int i);
      @(posedge clk_i);
      case (i)
         0:       rx_o.rdi_state <= ~rx_o.rdi_state;
         1:       rx_o.ais_state <= ~rx_o.ais_state;
         2:       rx_o.b2_err    <= 1'b1;
         default: rx_o.febe_err  <= 1'b1;
      endcase
      @(posedge clk_i);
      rx_o.b2_err   <= 1'b0;
      rx_o.febe_err <= 1'b0;
   endtask : fire

   // Error pulses spaced by gap+1 idle cycles, then the frame boundary
   task automatic frame(input int nb, input int nf, input int gap);
      for (int c = 0; c < nb || c < nf; c++)
      begin
         @(posedge clk_i);
         rx_o.b2_err   <= c < nb;
         rx_o.febe_err <= c < nf;
         @(posedge clk_i);
         rx_o.b2_err   <= 1'b0;
         rx_o.febe_err <= 1'b0;
         repeat (gap) @(posedge clk_i);
      end
      @(posedge clk_i);
      rx_o.frame <= 1'b1;
      @(posedge clk_i);
      rx_o.frame <= 1'b0;
   endtask : frame

   task automatic tx_frame();
      @(posedge clk_i);
      tx_frame_o <= 1'b1;
      @(posedge clk_i);
      tx_frame_o <= 1'b0;
   endtask : tx_frame

endmodule : slor_far_end

// >>> slor_line_oh_regs.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// How it works
// [R1] Remote defect state change sets its flag; reading the irq register clears.
// [R2] Alarm indication state change sets its flag; irq register read clears.
// [R3] Each B2 parity error sets the parity flag; irq register read clears.
// [R4] Each M1 far-end block error sets its flag; irq register read clears.
// [R5] Remote defect and alarm changes interrupt only when enabled.
// [R6] Parity and far-end errors interrupt only when their enables are set.
// [R7] Twenty-bit parity error count readable over three bytes since last poll.
// [R8] Twenty-bit far-end error count readable over three bytes since last poll.
// [R9] Write to any counter address latches both counts and restarts them.
// [R10] Global load write latches counters and tells the rest of the channel.
// [R11] Send remote defect puts 110 in outgoing K2 bits 6 to 8.
// [R12] APS source zero sends zero K1/K2, one sends register values.
// [R13] Inject bit inverts every transmitted B2 byte.
// [R14] K1 register bit 7 is sent first, bit 0 last.
// [R15] K1/K2 double buffered; K1 write starts both at next frame.
// [R16] Software spaces K1 writes at least two frames apart.
// [R17] Software writes K2 before K1 for a coherent code.
// [R18] Mode bit counts errors once per frame or once per bit.
// [R19] Interrupt output high while any enabled flag is set.
module slor_line_oh_regs
   import slor_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   // Framer receive and transmit side
   input  wire slor_rx_t    rx_i,
   input  wire logic        tx_frame_i,
   output slor_tx_t         tx_o,
   // Channel level
   output logic             perf_latch_o,
   output logic             irq_o
);

   slor_state_t st;
   slor_state_t nxt;
   logic        take;
   logic        mapped;
   logic [7:0]  a_idx;
   logic        wr;
   logic [7:0]  w;
   logic        poll;
   logic        rd_clr;
   logic [3:0]  clr;
   logic [3:0]  ev;
   logic        par_inc;
   logic        fe_inc;

   function automatic logic [SLOR_CNT_W-1:0] sat_inc
   (
      input logic [SLOR_CNT_W-1:0] v,
      input logic                  inc
   );
      if (inc && (v != '1))
      begin
         return SLOR_CNT_W'(v + 20'h00001);
      end
      return v;
   endfunction : sat_inc

   function automatic logic is_cnt(input logic [7:0] idx);
      return (idx >= SLOR_IDX_PAR_LO) && (idx <= SLOR_IDX_FE_HI);
   endfunction : is_cnt

   function automatic logic [31:0] rd_word
   (
      input slor_state_t s,
      input logic [7:0]  idx
   );
      logic [7:0] b;
      b = 8'h00;
      if (is_cnt(idx))
      begin
         unique case (idx)
            SLOR_IDX_PAR_LO:  b = s.par_cnt[7:0];                   // R7
            SLOR_IDX_PAR_MID: b = s.par_cnt[15:8];
            SLOR_IDX_PAR_HI:  b = {4'h0, s.par_cnt[19:16]};
            SLOR_IDX_FE_LO:   b = s.fe_cnt[7:0];                    // R8
            SLOR_IDX_FE_MID:  b = s.fe_cnt[15:8];
            default:          b = {4'h0, s.fe_cnt[19:16]};
         endcase
      end
      else
      begin
         case (idx)
            SLOR_IDX_RX_CTL:  b = {s.rx_ctl[7:2], s.ais_q, s.rdi_q};
            SLOR_IDX_IRQ:     b = {s.irq_en, s.irq_flag};
            SLOR_IDX_TX_CTL:  b = s.tx_ctl;
            SLOR_IDX_TX_DIAG: b = {7'h00, s.inject};
            SLOR_IDX_K1:      b = s.k1_buf;
            SLOR_IDX_K2:      b = s.k2_buf;
            default:          b = 8'h00;
         endcase
      end
      return {24'h000000, b};
   endfunction : rd_word

   always_comb
   begin
      nxt    = st;
      take   = hsel_i && htrans_i[1] && hready_i;
      mapped = (haddr_i[31:10] == 22'h000000) && (haddr_i[1:0] == 2'h0);
      a_idx  = mapped ? haddr_i[9:2] : 8'hFF;
      wr     = st.dp_wr;
      w      = hwdata_i[7:0];

      // Address phase: capture write target, read data for data phase
      nxt.dp_wr  = take && hwrite_i;
      nxt.dp_idx = a_idx;
      nxt.rdata  = (take && !hwrite_i) ? rd_word(st, a_idx) : 32'h00000000;

      // Status events; a set in the clearing cycle wins
      ev[SLOR_FLAG_RDI] = rx_i.rdi_state != st.rdi_q;                 // R1
      ev[SLOR_FLAG_AIS] = rx_i.ais_state != st.ais_q;                 // R2
      ev[SLOR_FLAG_PAR] = rx_i.b2_err;                                // R3
      ev[SLOR_FLAG_FE]  = rx_i.febe_err;                              // R4
      nxt.rdi_q = rx_i.rdi_state;
      nxt.ais_q = rx_i.ais_state;
      rd_clr = take && !hwrite_i && (a_idx == SLOR_IDX_IRQ);
      clr    = rd_clr ? 4'hF : 4'h0;
      if (wr && (st.dp_idx == SLOR_IDX_IRQ))
      begin
         clr        = clr | w[3:0];
         nxt.irq_en = w[7:4];
      end
      nxt.irq_flag = (st.irq_flag & ~clr) | ev;                   // R1 R2 R3 R4

      // Error accumulation per frame or per bit
      par_inc = st.rx_ctl[SLOR_PAR_WORD]                              // R18
              ? (rx_i.frame && (st.par_seen || rx_i.b2_err))
              : rx_i.b2_err;
      fe_inc  = st.rx_ctl[SLOR_FE_WORD]
              ? (rx_i.frame && (st.fe_seen || rx_i.febe_err))
              : rx_i.febe_err;
      nxt.par_seen = !rx_i.frame && (st.par_seen || rx_i.b2_err);
      nxt.fe_seen  = !rx_i.frame && (st.fe_seen || rx_i.febe_err);

      // Poll: latch both counts, restart keeping a coincident event
      nxt.perf_latch = wr && (st.dp_idx == SLOR_IDX_PERF_LOAD);       // R10
      poll = wr && (is_cnt(st.dp_idx) || nxt.perf_latch);             // R9
      if (poll)
      begin
         nxt.par_cnt = st.par_acc;                                    // R7
         nxt.fe_cnt  = st.fe_acc;                                     // R8
         nxt.par_acc = {{(SLOR_CNT_W-1){1'b0}}, par_inc};
         nxt.fe_acc  = {{(SLOR_CNT_W-1){1'b0}}, fe_inc};
      end
      else
      begin
         nxt.par_acc = sat_inc(st.par_acc, par_inc);
         nxt.fe_acc  = sat_inc(st.fe_acc, fe_inc);
      end

      // K1/K2 take effect at a frame boundary after a K1 write
      if (tx_frame_i && st.k_pend)
      begin
         nxt.k1_act = st.k1_buf;                                      // R15
         nxt.k2_act = st.k2_buf;
         nxt.k_pend = 1'b0;
      end

      // Data phase writes
      if (wr)
      begin
         case (st.dp_idx)
            SLOR_IDX_RX_CTL:  nxt.rx_ctl = {w[7:2], 2'h0};
            SLOR_IDX_TX_CTL:  nxt.tx_ctl = w;
            SLOR_IDX_TX_DIAG: nxt.inject = w[SLOR_INJECT];
            SLOR_IDX_K2:      nxt.k2_buf = w;
            SLOR_IDX_K1:
            begin
               nxt.k1_buf = w;
               nxt.k_pend = 1'b1;                                     // R15
            end
            default:          nxt.k_pend = nxt.k_pend;
         endcase
      end

      // Transmit overhead; bit 7 goes out first
      nxt.tx.k1 = st.tx_ctl[SLOR_APS_SEL] ? st.k1_act : 8'h00;     // R12 R14
      nxt.tx.k2 = st.tx_ctl[SLOR_APS_SEL] ? st.k2_act : 8'h00;     // R12
      if (st.tx_ctl[SLOR_SEND_RDI])
      begin
         nxt.tx.k2[2:0] = SLOR_RDI_CODE;                              // R11
      end
      nxt.tx.b2_inv = st.inject;                                      // R13
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         st <= SLOR_STATE_RST;
      end
      else
      begin
         st <= nxt;
      end
   end

   assign hreadyout_o  = 1'b1;
   assign hresp_o      = SLOR_HRESP_OKAY;
   assign hrdata_o     = st.rdata;
   assign tx_o         = st.tx;
   assign perf_latch_o = st.perf_latch;
   assign irq_o        = |(st.irq_flag & st.irq_en);          // R5 R6 R19

   localparam int POLL_MAX = SLOR_POLL_CYCLES;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_rdi_flag;
      $changed(rx_i.rdi_state) |=> st.irq_flag[SLOR_FLAG_RDI];
   endproperty
   a_rdi_flag: assert property (p_rdi_flag) // R1
      else $error("remote defect change did not set flag");

   property p_ais_flag;
      $changed(rx_i.ais_state) |=> st.irq_flag[SLOR_FLAG_AIS];
   endproperty
   a_ais_flag: assert property (p_ais_flag) // R2
      else $error("alarm change did not set flag");

   property p_par_flag;
      rx_i.b2_err |=> st.irq_flag[SLOR_FLAG_PAR];
   endproperty
   a_par_flag: assert property (p_par_flag) // R3
      else $error("parity error did not set flag");

   property p_fe_flag;
      rx_i.febe_err |=> st.irq_flag[SLOR_FLAG_FE];
   endproperty
   a_fe_flag: assert property (p_fe_flag) // R4
      else $error("far-end error did not set flag");

   property p_rdi_irq;
      $changed(rx_i.rdi_state) && st.irq_en[SLOR_FLAG_RDI] && !wr
         |=> irq_o;
   endproperty
   a_rdi_irq: assert property (p_rdi_irq) // R5
      else $error("enabled remote defect change gave no interrupt");

   property p_par_irq;
      rx_i.b2_err && st.irq_en[SLOR_FLAG_PAR] && !wr |=> irq_o;
   endproperty
   a_par_irq: assert property (p_par_irq) // R6
      else $error("enabled parity error gave no interrupt");

   property p_irq_release;
      rd_clr && (ev == 4'h0) && !wr |=> !irq_o;
   endproperty
   a_irq_release: assert property (p_irq_release) // R19
      else $error("interrupt stayed after status read");

   property p_par_latch;
      poll |=> st.par_cnt == $past(st.par_acc);
   endproperty
   a_par_latch: assert property (p_par_latch) // R7
      else $error("parity count not latched on poll");

   property p_fe_latch;
      poll |=> st.fe_cnt == $past(st.fe_acc);
   endproperty
   a_fe_latch: assert property (p_fe_latch) // R8
      else $error("far-end count not latched on poll");

   property p_restart;
      poll |-> ##[1:POLL_MAX] (st.par_acc <= 20'h00001)
         && (st.fe_acc <= 20'h00001);
   endproperty
   a_restart: assert property (p_restart) // R9
      else $error("accumulators not restarted after poll");

   property p_global_load;
      wr && (st.dp_idx == SLOR_IDX_PERF_LOAD)
         |=> perf_latch_o && (st.fe_cnt == $past(st.fe_acc));
   endproperty
   a_global_load: assert property (p_global_load) // R10
      else $error("global load did not latch counters");

   property p_send_rdi;
      st.tx_ctl[SLOR_SEND_RDI] |=> tx_o.k2[2:0] == SLOR_RDI_CODE;
   endproperty
   a_send_rdi: assert property (p_send_rdi) // R11
      else $error("K2 does not carry remote defect code");

   property p_aps_zero;
      !st.tx_ctl[SLOR_APS_SEL] && !st.tx_ctl[SLOR_SEND_RDI]
         |=> (tx_o.k1 == 8'h00) && (tx_o.k2 == 8'h00);
   endproperty
   a_aps_zero: assert property (p_aps_zero) // R12
      else $error("APS bytes not zero with source deselected");

   property p_inject;
      st.inject |=> tx_o.b2_inv;
   endproperty
   a_inject: assert property (p_inject) // R13
      else $error("B2 not inverted while injecting");

   property p_k_swap;
      tx_frame_i && st.k_pend |=> st.k1_act == $past(st.k1_buf)
         && st.k2_act == $past(st.k2_buf) ##1 tx_o.k1
         == ($past(st.tx_ctl[SLOR_APS_SEL]) ? $past(st.k1_act) : 8'h00);
   endproperty
   a_k_swap: assert property (p_k_swap) // R15
      else $error("buffered K1/K2 not taken at frame boundary");

   property p_bit_count;
      !st.rx_ctl[SLOR_PAR_WORD] && rx_i.b2_err && !poll
         && (st.par_acc != 20'hFFFFF)
         |=> st.par_acc == SLOR_CNT_W'($past(st.par_acc) + 20'h00001);
   endproperty
   a_bit_count: assert property (p_bit_count) // R18
      else $error("per-bit mode did not count the error");

   property p_ais_irq;
      $changed(rx_i.ais_state) && st.irq_en[SLOR_FLAG_AIS] && !wr
         |=> irq_o;
   endproperty
   a_ais_irq: assert property (p_ais_irq) // R5
      else $error("enabled alarm change gave no interrupt");

   property p_fe_irq;
      rx_i.febe_err && st.irq_en[SLOR_FLAG_FE] && !wr |=> irq_o;
   endproperty
   a_fe_irq: assert property (p_fe_irq) // R6
      else $error("enabled far-end error gave no interrupt");

   property p_flag_clear;
      rd_clr && (ev == 4'h0) |=> st.irq_flag == 4'h0;
   endproperty
   a_flag_clear: assert property (p_flag_clear) // R1 R2 R3 R4
      else $error("status read did not clear flags");

   property p_par_rd;
      take && !hwrite_i && (a_idx == SLOR_IDX_PAR_LO)
         |=> (hrdata_o[7:0] == $past(st.par_cnt[7:0]))
         && (hrdata_o[31:8] == 24'h000000);
   endproperty
   a_par_rd: assert property (p_par_rd) // R7
      else $error("parity count low byte read wrong");

   property p_fe_rd;
      take && !hwrite_i && (a_idx == SLOR_IDX_FE_HI)
         |=> hrdata_o[7:0] == {4'h0, $past(st.fe_cnt[19:16])};
   endproperty
   a_fe_rd: assert property (p_fe_rd) // R8
      else $error("far-end count high byte read wrong");

   property p_aps_k1;
      st.tx_ctl[SLOR_APS_SEL] |=> tx_o.k1 == $past(st.k1_act);
   endproperty
   a_aps_k1: assert property (p_aps_k1) // R12
      else $error("K1 byte does not carry the active value");

   property p_k_hold;
      !(tx_frame_i && st.k_pend)
         |=> $stable(st.k1_act) && $stable(st.k2_act);
   endproperty
   a_k_hold: assert property (p_k_hold) // R15
      else $error("active K1/K2 changed outside a frame boundary");

   property p_frame_count;
      st.rx_ctl[SLOR_PAR_WORD] && !rx_i.frame && !poll
         |=> $stable(st.par_acc);
   endproperty
   a_frame_count: assert property (p_frame_count) // R18
      else $error("per-frame mode counted inside a frame");

   property p_inject_off;
      !st.inject |=> !tx_o.b2_inv;
   endproperty
   a_inject_off: assert property (p_inject_off) // R13
      else $error("B2 inverted while injection is off");

endmodule : slor_line_oh_regs

// >>> slor_line_oh_regs_bench.sv
`timescale 1ns/1ps
module slor_line_oh_regs_bench
   import slor_pkg::*;
   ;

   logic        clk_i;
   logic        rst_b_i;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   slor_rx_t    rx;
   logic        tx_frame;
   slor_tx_t    tx;
   logic        perf_latch;
   logic        irq;
   int          fail_count;
   int          compares;
   int          cycles;
   int          n_latch;

   slor_line_oh_regs u_dut (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .hsel_i       (hsel),
      .haddr_i      (haddr),
      .htrans_i     (htrans),
      .hwrite_i     (hwrite),
      .hsize_i      (hsize),
      .hwdata_i     (hwdata),
      .hready_i     (hready),
      .hreadyout_o  (hready),
      .hresp_o      (hresp),
      .hrdata_o     (hrdata),
      .rx_i         (rx),
      .tx_frame_i   (tx_frame),
      .tx_o         (tx),
      .perf_latch_o (perf_latch),
      .irq_o        (irq)
   );

   slor_far_end u_far (
      .clk_i      (clk_i),
      .rx_o       (rx),
      .tx_frame_o (tx_frame)
   );

   initial clk_i = 1'b0;
   always #25 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      cycles++;
      if (perf_latch === 1'b1)
         n_latch++;
      if (cycles == 20000)
      begin
         fail_count++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
   end

   task automatic test_done();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp, input string w);
      chk_byte({7'h0, got}, {7'h0, exp}, w);
   endtask : chk_bit

   // One single word transfer; waits on hready in both phases
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] rd);
      @(posedge clk_i);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= 3'h2;
      haddr  <= {22'h0, idx, 2'h0};
      do @(posedge clk_i); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk_i); while (hready !== 1'b1);
      rd = hrdata[7:0];
      chk_bit(hresp, SLOR_HRESP_OKAY, "resp");
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] unused;
      bus(1'b1, idx, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                         input string what);
      logic [7:0] v;
      bus(1'b0, idx, 8'h00, v);
      chk_byte(v, exp, what);
   endtask : rd_chk

   task automatic t_reset();
      @(posedge clk_i);
      chk_byte(tx.k1, 8'h00, "k1 rst");
      chk_byte(tx.k2, 8'h00, "k2 rst");
      chk_bit(irq, 1'b0, "irq rst");
      rd_chk(SLOR_IDX_TX_CTL, 8'h00, "ctl rst");
      rd_chk(SLOR_IDX_K1, 8'h00, "k1 reg rst");
      rd_chk(SLOR_IDX_IRQ, 8'h00, "irq reg rst");
      wr(8'h3F, 8'hFF);
      rd_chk(8'h3F, 8'h00, "unmapped");
   endtask : t_reset

   // Each event once masked by its own enable, once with all enabled
   task automatic t_irq();
      logic [3:0] en;
      for (int m = 0; m < 2; m++)
         for (int i = 0; i < 4; i++)
         begin
            en = (m == 1) ? 4'hF : ~(4'h1 << i);
            wr(SLOR_IDX_IRQ, {en, 4'h0});
            u_far.fire(i);
            @(posedge clk_i);
            chk_bit(irq, m == 1, "irq level");
            rd_chk(SLOR_IDX_IRQ, {en, (4'h1 << i)}, "flags");
            @(posedge clk_i);
            chk_bit(irq, 1'b0, "irq release");
         end
      u_far.fire(2);
      wr(SLOR_IDX_IRQ, 8'h04);
      rd_chk(SLOR_IDX_IRQ, 8'h00, "w1c");
   endtask : t_irq

   task automatic t_count(input logic [7:0] mode, input int nb, input int nf,
                          input int frames, input int gap,
                          input logic [7:0] poll);
      int p;
      int f;
      int n0;
      wr(SLOR_IDX_RX_CTL, mode);
      wr(SLOR_IDX_PAR_LO, 8'h00);
      repeat (frames) u_far.frame(nb, nf, gap);
      n0 = n_latch;
      wr(poll, 8'h00);
      repeat (3) @(posedge clk_i);
      f = (poll == SLOR_IDX_PERF_LOAD) ? n0 + 1 : n0;
      chk_bit(n_latch == f, 1'b1, "meter load");
      p = mode[SLOR_PAR_WORD] ? frames : frames * nb;
      f = mode[SLOR_FE_WORD] ? frames : frames * nf;
      rd_chk(SLOR_IDX_PAR_LO, p[7:0], "par lo");
      rd_chk(SLOR_IDX_PAR_MID, p[15:8], "par mid");
      rd_chk(SLOR_IDX_PAR_HI, {4'h0, p[19:16]}, "par hi");
      rd_chk(SLOR_IDX_FE_LO, f[7:0], "fe lo");
      rd_chk(SLOR_IDX_FE_MID, f[15:8], "fe mid");
      rd_chk(SLOR_IDX_FE_HI, {4'h0, f[19:16]}, "fe hi");
      wr(SLOR_IDX_FE_HI, 8'h00);
      repeat (3) @(posedge clk_i);
      rd_chk(SLOR_IDX_PAR_LO, 8'h00, "restart");
   endtask : t_count

   task automatic t_tx();
      wr(SLOR_IDX_TX_CTL, 8'h00);
      wr(SLOR_IDX_K2, 8'h71);
      wr(SLOR_IDX_K1, 8'hB4);
      u_far.tx_frame();
      repeat (2) @(posedge clk_i);
      chk_byte(tx.k1, 8'h00, "aps off k1");
      chk_byte(tx.k2, 8'h00, "aps off k2");
      wr(SLOR_IDX_TX_CTL, 8'h20);
      repeat (2) @(posedge clk_i);
      chk_byte(tx.k1, 8'hB4, "k1 order");
      chk_byte(tx.k2, 8'h71, "k2 on");
      // Two frames between K1 writes
      repeat (2)
      begin
         repeat (2500) @(posedge clk_i);
         u_far.tx_frame();
      end
      wr(SLOR_IDX_K2, 8'h93);
      wr(SLOR_IDX_K1, 8'hC1);
      repeat (4) @(posedge clk_i);
      chk_byte(tx.k1, 8'hB4, "k1 held");
      chk_byte(tx.k2, 8'h71, "k2 held");
      u_far.tx_frame();
      repeat (2) @(posedge clk_i);
      chk_byte(tx.k1, 8'hC1, "k1 new");
      chk_byte(tx.k2, 8'h93, "k2 new");
      wr(SLOR_IDX_TX_CTL, 8'h21);
      repeat (2) @(posedge clk_i);
      chk_byte(tx.k2, 8'h96, "rdi on");
      wr(SLOR_IDX_TX_CTL, 8'h01);
      repeat (2) @(posedge clk_i);
      chk_byte(tx.k2, 8'h06, "rdi only");
      chk_byte(tx.k1, 8'h00, "k1 off");
      wr(SLOR_IDX_TX_DIAG, 8'h01);
      repeat (100) @(posedge clk_i);
      chk_bit(tx.b2_inv, 1'b1, "inject on");
      wr(SLOR_IDX_TX_DIAG, 8'h00);
      repeat (2) @(posedge clk_i);
      chk_bit(tx.b2_inv, 1'b0, "inject off");
      rd_chk(SLOR_IDX_K1, 8'hC1, "k1 read");
      rd_chk(SLOR_IDX_TX_CTL, 8'h01, "ctl read");
   endtask : t_tx

   initial
   begin
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0;
      rst_b_i    = 1'b0;
      fail_count = 0;
      compares   = 0;
      cycles     = 0;
      n_latch    = 0;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_irq();
      t_count(8'h00, 5, 3, 2, 0, SLOR_IDX_PAR_HI);
      t_count(8'h80, 24, 2, 3, 2, SLOR_IDX_PERF_LOAD);
      t_count(8'h04, 4, 1, 2, 1, SLOR_IDX_FE_MID);
      t_tx();
      test_done();
   end

endmodule : slor_line_oh_regs_bench

// >>> slor_pkg.sv
package slor_pkg;

   // Timing
   localparam int SLOR_CLK_PERIOD_NS = 50;
   localparam int SLOR_POLL_TIME_NS  = 7000;
   localparam int SLOR_POLL_CYCLES   = SLOR_POLL_TIME_NS / SLOR_CLK_PERIOD_NS;

   // Widths
   localparam int SLOR_CNT_W = 20;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] SLOR_IDX_PERF_LOAD = 8'h05;
   localparam logic [7:0] SLOR_IDX_RX_CTL    = 8'h18;
   localparam logic [7:0] SLOR_IDX_IRQ       = 8'h19;
   localparam logic [7:0] SLOR_IDX_PAR_LO    = 8'h1A;
   localparam logic [7:0] SLOR_IDX_PAR_MID   = 8'h1B;
   localparam logic [7:0] SLOR_IDX_PAR_HI    = 8'h1C;
   localparam logic [7:0] SLOR_IDX_FE_LO     = 8'h1D;
   localparam logic [7:0] SLOR_IDX_FE_MID    = 8'h1E;
   localparam logic [7:0] SLOR_IDX_FE_HI     = 8'h1F;
   localparam logic [7:0] SLOR_IDX_TX_CTL    = 8'h20;
   localparam logic [7:0] SLOR_IDX_TX_DIAG   = 8'h21;
   localparam logic [7:0] SLOR_IDX_K1        = 8'h22;
   localparam logic [7:0] SLOR_IDX_K2        = 8'h23;

   // Field positions
   localparam int SLOR_FLAG_RDI     = 0;
   localparam int SLOR_FLAG_AIS     = 1;
   localparam int SLOR_FLAG_PAR     = 2;
   localparam int SLOR_FLAG_FE      = 3;
   localparam int SLOR_PAR_WORD     = 7;
   localparam int SLOR_FE_WORD      = 2;
   localparam int SLOR_SEND_RDI     = 0;
   localparam int SLOR_APS_SEL      = 5;
   localparam int SLOR_INJECT       = 0;

   // Codes
   localparam logic [2:0] SLOR_RDI_CODE   = 3'h6;
   localparam logic       SLOR_HRESP_OKAY = 1'h0;

   typedef struct packed {
      logic frame;
      logic b2_err;
      logic febe_err;
      logic rdi_state;
      logic ais_state;
   } slor_rx_t;

   typedef struct packed {
      logic [7:0] k1;
      logic [7:0] k2;
      logic       b2_inv;
   } slor_tx_t;

   typedef struct packed {
      logic                  dp_wr;
      logic [7:0]            dp_idx;
      logic [31:0]           rdata;
      logic                  perf_latch;
      logic [3:0]            irq_en;
      logic [3:0]            irq_flag;
      logic                  rdi_q;
      logic                  ais_q;
      logic [7:0]            rx_ctl;
      logic [SLOR_CNT_W-1:0] par_acc;
      logic [SLOR_CNT_W-1:0] fe_acc;
      logic [SLOR_CNT_W-1:0] par_cnt;
      logic [SLOR_CNT_W-1:0] fe_cnt;
      logic                  par_seen;
      logic                  fe_seen;
      logic [7:0]            tx_ctl;
      logic                  inject;
      logic [7:0]            k1_buf;
      logic [7:0]            k2_buf;
      logic [7:0]            k1_act;
      logic [7:0]            k2_act;
      logic                  k_pend;
      slor_tx_t              tx;
   } slor_state_t;

   localparam slor_state_t SLOR_STATE_RST = '0;

endpackage : slor_pkg
